// >>> rtl/bmr_decode.sv
// combinational address decoder for the three memory maps
`timescale 1ns/1ps
`default_nettype none
module bmr_decode (
    // address and active map
    input  wire logic [31:0]      i_addr,
    input  wire bmr_pkg::bmr_map_t i_map,
    // decoded target
    output bmr_pkg::bmr_sel_t     o_sel
);
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] s);
        in_win = (a >= b) && (a - b < s);
    endfunction : in_win

    always_comb begin
        o_sel.target = bmr_pkg::TGT_NONE;
        o_sel.offset = 32'h0000_0000;
        if (i_map == bmr_pkg::BMR_BOOT && i_addr <= bmr_pkg::ROM_ALIAS_TOP) begin
            o_sel.target = bmr_pkg::TGT_ROM; // RULE3
            o_sel.offset = i_addr & (bmr_pkg::ROM_SIZE - 32'h1);
        end else if (i_map == bmr_pkg::BMR_BOOT
                     && in_win(i_addr, bmr_pkg::PF1_RST_BASE, bmr_pkg::PF_SIZE)) begin
            o_sel.target = bmr_pkg::TGT_PF1; // RULE2
            o_sel.offset = i_addr - bmr_pkg::PF1_RST_BASE;
        end else if (i_map == bmr_pkg::BMR_BOOT
                     && in_win(i_addr, bmr_pkg::PF2_RST_BASE, bmr_pkg::PF_SIZE)) begin
            o_sel.target = bmr_pkg::TGT_PF2; // RULE2
            o_sel.offset = i_addr - bmr_pkg::PF2_RST_BASE;
        end else if (i_map != bmr_pkg::BMR_BOOT
                     && in_win(i_addr, bmr_pkg::PF_LO_BASE, bmr_pkg::PF_SIZE)) begin
            // RULE4 RULE6 RULE7 RULE12
            o_sel.target = (i_map == bmr_pkg::BMR_PF1) ? bmr_pkg::TGT_PF1 : bmr_pkg::TGT_PF2;
            o_sel.offset = i_addr - bmr_pkg::PF_LO_BASE;
        end else if (i_map != bmr_pkg::BMR_BOOT
                     && in_win(i_addr, bmr_pkg::PF_HI_BASE, bmr_pkg::PF_SIZE)) begin
            // RULE4 RULE6 RULE7 RULE12
            o_sel.target = (i_map == bmr_pkg::BMR_PF1) ? bmr_pkg::TGT_PF2 : bmr_pkg::TGT_PF1;
            o_sel.offset = i_addr - bmr_pkg::PF_HI_BASE;
        end else if (i_map != bmr_pkg::BMR_BOOT
                     && in_win(i_addr, bmr_pkg::ROM_NORM_BASE, bmr_pkg::ROM_SIZE)) begin
            o_sel.target = bmr_pkg::TGT_ROM; // RULE4
            o_sel.offset = i_addr - bmr_pkg::ROM_NORM_BASE;
        end else if (in_win(i_addr, bmr_pkg::DF_BASE, bmr_pkg::DF_SIZE)) begin
            o_sel.target = bmr_pkg::TGT_DF; // RULE2
            o_sel.offset = i_addr - bmr_pkg::DF_BASE;
        end else if (in_win(i_addr, bmr_pkg::RAM_BASE, bmr_pkg::RAM_SIZE)) begin
            o_sel.target = bmr_pkg::TGT_RAM; // RULE2
            o_sel.offset = i_addr - bmr_pkg::RAM_BASE;
        end else if (i_addr >= bmr_pkg::PER_BASE
                     && i_addr[15:0] < bmr_pkg::PER_SIZE[15:0]
                     && i_addr[31:16] - bmr_pkg::PER_BASE[31:16] < 16'(bmr_pkg::PER_COUNT)) begin
            // RULE11
            o_sel.target = bmr_pkg::TGT_PER0
                         + 8'(i_addr[31:16] - bmr_pkg::PER_BASE[31:16]);
            o_sel.offset = {24'h00_0000, i_addr[7:0]};
        end
    end
endmodule : bmr_decode
`default_nettype wire

// >>> rtl/bmr_pkg.sv
// package: memory map constants and types for the boot remap decoder
package bmr_pkg;
    localparam logic [31:0] ROM_ALIAS_TOP   = 32'h0003_ffff;
    localparam logic [31:0] ROM_SIZE        = 32'h0000_2000;
    localparam logic [31:0] ROM_NORM_BASE   = 32'h0002_0000;
    localparam logic [31:0] PF1_RST_BASE    = 32'h0004_0000;
    localparam logic [31:0] PF2_RST_BASE    = 32'h0004_8000;
    localparam logic [31:0] PF_SIZE         = 32'h0000_8000;
    localparam logic [31:0] PF_LO_BASE      = 32'h0000_0000;
    localparam logic [31:0] PF_HI_BASE      = 32'h0000_8000;
    localparam logic [31:0] DF_BASE         = 32'h0006_8800;
    localparam logic [31:0] DF_SIZE         = 32'h0000_0800;
    localparam logic [31:0] RAM_BASE        = 32'h0006_9000;
    localparam logic [31:0] RAM_SIZE        = 32'h0000_1000;
    localparam logic [31:0] PER_BASE        = 32'h0012_0000;
    localparam logic [31:0] PER_STEP        = 32'h0001_0000;
    localparam logic [31:0] PER_SIZE        = 32'h0000_0100;
    localparam int          PER_COUNT       = 13;
    localparam int          CK_BYTES        = 2048;
    localparam logic [7:0]  TGT_NONE        = 8'h00;
    localparam logic [7:0]  TGT_ROM         = 8'h01;
    localparam logic [7:0]  TGT_PF1         = 8'h02;
    localparam logic [7:0]  TGT_PF2         = 8'h03;
    localparam logic [7:0]  TGT_DF          = 8'h04;
    localparam logic [7:0]  TGT_RAM         = 8'h05;
    localparam logic [7:0]  TGT_PER0        = 8'h10;

    typedef enum logic [1:0] {
        BMR_BOOT = 2'b00,
        BMR_PF1  = 2'b01,
        BMR_PF2  = 2'b11
    } bmr_map_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bmr_req_t;

    typedef struct packed {
        logic [7:0]  target;
        logic [31:0] offset;
    } bmr_sel_t;
endpackage : bmr_pkg

// >>> rtl/bmr_remap.sv
// boot remap controller: boot flow sequencing, map select and bus routing
// Notes on behaviour
// RULE1 - after reset execution starts in boot rom, which then evaluates flash banks
// RULE2 - post-reset map: flash1 0x40000, flash2 0x48000, data flash 0x68800, ram above
// RULE3 - post-reset map: 8k boot rom aliased 32 times below 0x40000
// RULE4 - normal map: banks at 0 and 0x8000, rom at 0x20000, data unchanged
// RULE5 - checksum first 2kB of each bank; valid one is branched to
// RULE6 - bank one selected: bank one at 0x0000, bank two at 0x8000
// RULE7 - bank two selected: bank two at 0x0000, bank one at 0x8000
// RULE8 - if first checksums fail, full checks pick the valid bank
// RULE9 - no valid checksum: stay in rom, serve host commands on all memory
// RULE10 - host then downloads program to flash and commands its execution
// RULE11 - peripherals get 256-byte windows from 0x120000 stepping 0x10000
// RULE12 - bank at zero is the chosen bank, other bank in upper 32k
// RULE13 - map switch is a single atomic update before the flash branch
// RULE14 - unmapped reads return zero, writes ignored, no stall
`timescale 1ns/1ps
`default_nettype none
module bmr_remap (
    // clock, reset, enable
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    input  wire logic              i_ce,
    // processor request
    input  wire bmr_pkg::bmr_req_t i_req,
    // checksum results from boot firmware evaluation
    input  wire logic              i_ck_done,
    input  wire logic              i_ck1_short_ok,
    input  wire logic              i_ck2_short_ok,
    input  wire logic              i_ck1_full_ok,
    input  wire logic              i_ck2_full_ok,
    // host command requests execution of a bank (1 = bank one, 0 = bank two)
    input  wire logic              i_host_run,
    input  wire logic              i_host_bank1,
    // read data from the targets
    input  wire logic [31:0]       i_tgt_rdata,
    // routed access
    output logic                   o_tgt_valid,
    output logic                   o_tgt_write,
    output bmr_pkg::bmr_sel_t      o_tgt_sel,
    output logic [31:0]            o_tgt_wdata,
    output logic                   o_ready,
    output logic [31:0]            o_rdata,
    // status
    output bmr_pkg::bmr_map_t      o_map,
    output logic                   o_host_mode,
    output logic                   o_ck_len
);
    bmr_pkg::bmr_map_t map_q, map_d;
    logic              host_q, host_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              done_q, done_d;
    bmr_pkg::bmr_sel_t sel;

    bmr_decode u_dec (
        .i_addr (i_req.addr),
        .i_map  (map_q),
        .o_sel  (sel)
    );

    // map state: one register holds the whole map so the switch cannot tear
    always_comb begin
        map_d  = map_q;
        host_d = host_q;
        done_d = done_q;
        if (map_q == bmr_pkg::BMR_BOOT && !done_q && i_ck_done) begin
            done_d = 1'b1;
            if (i_ck1_short_ok) begin
                map_d = bmr_pkg::BMR_PF1; // RULE5 RULE6 RULE13
            end else if (i_ck2_short_ok) begin
                map_d = bmr_pkg::BMR_PF2; // RULE5 RULE7 RULE13
            end else if (i_ck1_full_ok) begin
                map_d = bmr_pkg::BMR_PF1; // RULE8
            end else if (i_ck2_full_ok) begin
                map_d = bmr_pkg::BMR_PF2; // RULE8
            end else begin
                host_d = 1'b1; // RULE9
            end
        end else if (host_q && i_host_run) begin
            // RULE10 RULE13
            map_d  = i_host_bank1 ? bmr_pkg::BMR_PF1 : bmr_pkg::BMR_PF2;
            host_d = 1'b0;
        end
    end

    // zero for unmapped reads, registered and answered the cycle after
    always_comb begin
        rdata_d = rdata_q;
        if (i_req.valid && !i_req.write) begin
            rdata_d = (sel.target == bmr_pkg::TGT_NONE) ? 32'h0000_0000 : i_tgt_rdata; // RULE14
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            map_q   <= bmr_pkg::BMR_BOOT; // RULE1
            host_q  <= 1'b0;
            done_q  <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            map_q   <= map_d;
            host_q  <= host_d;
            done_q  <= done_d;
            rdata_q <= rdata_d;
        end
    end

    // unmapped writes never reach a target
    assign o_tgt_valid = i_req.valid && (sel.target != bmr_pkg::TGT_NONE); // RULE14
    assign o_tgt_write = i_req.write;
    assign o_tgt_sel   = sel;
    assign o_tgt_wdata = i_req.wdata;
    assign o_ready     = 1'b1; // RULE14
    assign o_rdata     = rdata_q;
    assign o_map       = map_q;
    assign o_host_mode = host_q;
    assign o_ck_len    = (bmr_pkg::CK_BYTES == 2048);

    // reset state
    a_reset_boot_map: assert property (@(posedge i_ref_clk) // RULE1
        $rose(!i_reset) |-> map_q == bmr_pkg::BMR_BOOT)
        else $error("map not boot after reset");
    a_reset_clear_state: assert property (@(posedge i_ref_clk) // RULE1
        $rose(!i_reset) |-> !host_q && !done_q && o_rdata == 32'h0000_0000)
        else $error("host state or read data not cleared by reset");

    // post-reset map
    a_rom_alias_low: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE3
        map_q == bmr_pkg::BMR_BOOT && i_req.addr <= bmr_pkg::ROM_ALIAS_TOP
        |-> sel.target == bmr_pkg::TGT_ROM && sel.offset == {19'h0, i_req.addr[12:0]})
        else $error("rom alias decode wrong");
    a_pf1_boot_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE2
        map_q == bmr_pkg::BMR_BOOT && i_req.addr[31:15] == 17'h00008
        |-> sel.target == bmr_pkg::TGT_PF1 && sel.offset == {17'h0, i_req.addr[14:0]})
        else $error("bank one post-reset decode wrong");
    a_boot_pf2_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE2
        map_q == bmr_pkg::BMR_BOOT && i_req.addr[31:15] == 17'h00009
        |-> sel.target == bmr_pkg::TGT_PF2)
        else $error("bank two post-reset decode wrong");
    a_boot_gap_none: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE2
        map_q == bmr_pkg::BMR_BOOT && i_req.addr[31:16] == 16'h0005
        |-> sel.target == bmr_pkg::TGT_NONE)
        else $error("gap above the flash banks decoded");

    // normal-operation map
    a_bank1_at_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE6
        map_q == bmr_pkg::BMR_PF1 && i_req.addr[31:15] == 17'h0
        |-> sel.target == bmr_pkg::TGT_PF1)
        else $error("bank one not at zero");
    a_bank2_swap: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE7
        map_q == bmr_pkg::BMR_PF2 && i_req.addr[31:15] == 17'h1
        |-> sel.target == bmr_pkg::TGT_PF1)
        else $error("bank one not at 0x8000 when bank two chosen");
    a_norm_pf_offset: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE12
        map_q != bmr_pkg::BMR_BOOT && i_req.addr[31:16] == 16'h0000
        |-> sel.offset == {17'h0, i_req.addr[14:0]})
        else $error("flash offset wrong in normal map");
    a_rom_norm_win: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE4
        map_q != bmr_pkg::BMR_BOOT && i_req.addr[31:13] == 19'h00010
        |-> sel.target == bmr_pkg::TGT_ROM && sel.offset == {19'h0, i_req.addr[12:0]})
        else $error("rom window wrong in normal map");
    a_norm_low_gap: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE4
        map_q != bmr_pkg::BMR_BOOT && i_req.addr[31:16] == 16'h0001
        |-> sel.target == bmr_pkg::TGT_NONE)
        else $error("rom alias left in normal map");
    a_norm_old_banks: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE4
        map_q != bmr_pkg::BMR_BOOT && i_req.addr[31:16] == 16'h0004
        |-> sel.target == bmr_pkg::TGT_NONE)
        else $error("post-reset flash windows left in normal map");

    // windows common to both maps
    a_data_flash_win: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE2
        i_req.addr[31:11] == 21'h000d1
        |-> sel.target == bmr_pkg::TGT_DF && sel.offset == {21'h0, i_req.addr[10:0]})
        else $error("data flash window wrong");
    a_data_ram_win: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE2
        i_req.addr[31:12] == 20'h00069
        |-> sel.target == bmr_pkg::TGT_RAM && sel.offset == {20'h0, i_req.addr[11:0]})
        else $error("data ram window wrong");
    a_periph_window: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE11
        i_req.addr[31:8] == 24'h00_1200
        |-> sel.target == bmr_pkg::TGT_PER0 && sel.offset == {24'h0, i_req.addr[7:0]})
        else $error("first peripheral window wrong");
    a_periph_gap: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE11
        i_req.addr[31:20] == 12'h001 && i_req.addr[19:16] >= 4'h2
        && i_req.addr[15:8] != 8'h00 |-> sel.target == bmr_pkg::TGT_NONE)
        else $error("space between peripheral windows decoded");
    a_periph_last: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE11
        i_req.addr[31:16] == 16'h001f |-> sel.target == bmr_pkg::TGT_NONE)
        else $error("window decoded past the last peripheral");

    // bank choice from the checksum results
    a_short1_first: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE6
        i_ce && map_q == bmr_pkg::BMR_BOOT && !done_q && i_ck_done && i_ck1_short_ok
        |=> map_q == bmr_pkg::BMR_PF1)
        else $error("bank one short checksum not taken");
    a_short_ck_pick: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE5
        i_ce && map_q == bmr_pkg::BMR_BOOT && !done_q && i_ck_done && !i_ck1_short_ok
        && i_ck2_short_ok |=> map_q == bmr_pkg::BMR_PF2)
        else $error("bank two short checksum not taken");
    a_full_ck_pick: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE8
        i_ce && map_q == bmr_pkg::BMR_BOOT && !done_q && i_ck_done && !i_ck1_short_ok
        && !i_ck2_short_ok && i_ck1_full_ok |=> map_q == bmr_pkg::BMR_PF1)
        else $error("bank one full checksum not taken");
    a_no_ck_host: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE9
        i_ce && map_q == bmr_pkg::BMR_BOOT && !done_q && i_ck_done && !i_ck1_short_ok
        && !i_ck2_short_ok && !i_ck1_full_ok && !i_ck2_full_ok
        |=> host_q && map_q == bmr_pkg::BMR_BOOT)
        else $error("boot rom not kept in control");
    a_late_ck_ignored: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE9
        done_q && map_q == bmr_pkg::BMR_BOOT && !(i_ce && host_q && i_host_run)
        |=> map_q == bmr_pkg::BMR_BOOT)
        else $error("map left boot without a host run");
    a_host_run_map: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE9
        i_ce && host_q && i_host_run
        |=> !host_q && map_q != bmr_pkg::BMR_BOOT
            && (map_q == bmr_pkg::BMR_PF1) == $past(i_host_bank1))
        else $error("host run picked the wrong bank");

    // map changes only out of boot and never tears
    a_map_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE13
        map_q != bmr_pkg::BMR_BOOT |=> map_q == $past(map_q))
        else $error("normal map changed before reset");
    a_ce_freeze: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE13
        !i_ce |=> $stable(map_q) && $stable(host_q) && $stable(done_q) && $stable(o_rdata))
        else $error("state moved while clock enable low");

    // bus routing
    a_unmapped_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE14
        i_ce && i_req.valid && !i_req.write && sel.target == bmr_pkg::TGT_NONE
        |=> o_rdata == 32'h0000_0000 && !$past(o_tgt_valid))
        else $error("unmapped read not zero");
    a_unmapped_write: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE14
        i_req.valid && i_req.write && sel.target == bmr_pkg::TGT_NONE
        |-> !o_tgt_valid && o_ready)
        else $error("unmapped write reached a target");
    a_mapped_pass: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE9
        i_req.valid && sel.target != bmr_pkg::TGT_NONE
        |-> o_tgt_valid && o_tgt_write == i_req.write && o_tgt_wdata == i_req.wdata)
        else $error("mapped access not passed to target");

    c_boot_pf1: cover property (@(posedge i_ref_clk) map_q == bmr_pkg::BMR_PF1);
    c_boot_pf2: cover property (@(posedge i_ref_clk) map_q == bmr_pkg::BMR_PF2);
    c_host_mode: cover property (@(posedge i_ref_clk) host_q ##1 !host_q);
    c_full_ck: cover property (@(posedge i_ref_clk)
        i_ck_done && !done_q && !i_ck1_short_ok && !i_ck2_short_ok && i_ck1_full_ok);
    c_unmapped_read: cover property (@(posedge i_ref_clk)
        i_req.valid && !i_req.write && sel.target == bmr_pkg::TGT_NONE);
endmodule : bmr_remap
`default_nettype wire

// >>> verif/bmr_cpu_model.sv
// processor core model: one access per call on the request port
`timescale 1ns/1ps
`default_nettype none
module bmr_cpu_model (
    // clock
    input  wire logic             i_ref_clk,
    // request towards the decoder
    output var bmr_pkg::bmr_req_t o_req
);
    initial o_req = '0;
    // launched just after an edge, held for one whole cycle
    task automatic drive(input logic v, input logic w, input logic [31:0] a);
        @(posedge i_ref_clk);
        o_req <= '{valid: v, write: w, addr: v ? a : ~a, wdata: ~a};
    endtask : drive
endmodule : bmr_cpu_model
`default_nettype wire

// >>> verif/boot_memory_map_remap_tb.sv
// self-checking bench for the boot remap controller
`timescale 1ns/1ps
`default_nettype none
module boot_memory_map_remap_tb;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              done = 1'b0;
    logic [3:0]        ok = 4'h0;
    logic              run = 1'b0;
    logic              bank1 = 1'b0;
    logic              ce = 1'b1;
    bmr_pkg::bmr_req_t req;
    bmr_pkg::bmr_sel_t sel;
    bmr_pkg::bmr_map_t map;
    logic              tv, tw, rdy, hm, ckl;
    logic [31:0]       twd, rd, trd;
    int                n_errors = 0;
    int                num_checks = 0;
    int                cyc = 0;

    always #2.5 clk = ~clk;
    // targets answer with their own code; nothing selected gives a moving pattern
    assign trd = tv ? {sel.target, sel.offset[23:0]} : ~cyc;

    bmr_cpu_model cpu (.i_ref_clk(clk), .o_req(req));
    bmr_remap dut (
        .i_ref_clk(clk), .i_reset(rst), .i_ce(ce), .i_req(req),
        .i_ck_done(done), .i_ck1_short_ok(ok[0]), .i_ck2_short_ok(ok[1]),
        .i_ck1_full_ok(ok[2]), .i_ck2_full_ok(ok[3]),
        .i_host_run(run), .i_host_bank1(bank1), .i_tgt_rdata(trd),
        .o_tgt_valid(tv), .o_tgt_write(tw), .o_tgt_sel(sel), .o_tgt_wdata(twd),
        .o_ready(rdy), .o_rdata(rd), .o_map(map), .o_host_mode(hm), .o_ck_len(ckl)
    );

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // read one word and judge routing and returned data
    task automatic acc(input logic [31:0] a, input logic [7:0] t, input logic [31:0] o);
        cpu.drive(1'b1, 1'b0, a);
        #1;
        chk("valid", {39'h0, t != bmr_pkg::TGT_NONE}, {39'h0, tv});
        chk("ready", 40'h1, {39'h0, rdy});
        chk("write", 40'h0, {39'h0, tw});
        if (t != bmr_pkg::TGT_NONE) chk("sel", {t, o}, sel);
        cpu.drive(1'b0, 1'b0, a);
        #1;
        chk("rdata", t == bmr_pkg::TGT_NONE ? 40'h0 : {16'h0, o[23:0]} | {t, 32'h0} >> 8,
            {8'h0, rd});
    endtask : acc

    task automatic reset_all;
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask : reset_all

    // map must jump straight from boot to the final choice
    task automatic decide(input logic [3:0] k, input bmr_pkg::bmr_map_t m);
        @(posedge clk);
        done <= 1'b1;
        ok <= k;
        #1;
        chk("map early", {38'h0, bmr_pkg::BMR_BOOT}, {38'h0, map});
        @(posedge clk);
        done <= 1'b0;
        #1;
        chk("map", {38'h0, m}, {38'h0, map});
    endtask : decide

    task automatic t_boot_map;
        reset_all();
        chk("map", {38'h0, bmr_pkg::BMR_BOOT}, {38'h0, map});
        chk("host", 40'h0, {39'h0, hm});
        chk("ck len", 40'h1, {39'h0, ckl});
        acc(32'h0000_0000, bmr_pkg::TGT_ROM, 32'h0);
        acc(32'h0003_e004, bmr_pkg::TGT_ROM, 32'h4);
        acc(32'h0004_0010, bmr_pkg::TGT_PF1, 32'h10);
        acc(32'h0004_8020, bmr_pkg::TGT_PF2, 32'h20);
        acc(32'h0006_8800, bmr_pkg::TGT_DF, 32'h0);
        acc(32'h0006_9ffc, bmr_pkg::TGT_RAM, 32'hffc);
        acc(32'h0012_0000, bmr_pkg::TGT_PER0, 32'h0);
        acc(32'h001e_00ff, 8'h1c, 32'hff);
        acc(32'h0012_0100, bmr_pkg::TGT_NONE, 32'h0);
        cpu.drive(1'b1, 1'b1, 32'h0006_9004);
        #1;
        chk("wr sel", {bmr_pkg::TGT_RAM, 32'h4}, sel);
        chk("wr pass", {6'h0, 2'b11, ~32'h0006_9004}, {6'h0, tv, tw, twd});
        cpu.drive(1'b1, 1'b1, 32'h0005_0000);
        #1;
        chk("wr valid", 40'h0, {39'h0, tv});
        cpu.drive(1'b0, 1'b0, 32'h0);
        $display("test boot map done");
    endtask : t_boot_map

    task automatic t_normal(input logic [3:0] k, input bmr_pkg::bmr_map_t m,
                            input logic [7:0] lo, input logic [7:0] hi);
        reset_all();
        decide(k, m);
        acc(32'h0000_0000, lo, 32'h0);
        acc(32'h0000_8004, hi, 32'h4);
        acc(32'h0002_1ffc, bmr_pkg::TGT_ROM, 32'h1ffc);
        acc(32'h0002_2000, bmr_pkg::TGT_NONE, 32'h0);
        acc(32'h0006_8804, bmr_pkg::TGT_DF, 32'h4);
        acc(32'h0006_9000, bmr_pkg::TGT_RAM, 32'h0);
        $display("test normal map %h done", k);
    endtask : t_normal

    task automatic t_host(input logic b1);
        reset_all();
        decide(4'h0, bmr_pkg::BMR_BOOT);
        chk("host", 40'h1, {39'h0, hm});
        acc(32'h0004_8000, bmr_pkg::TGT_PF2, 32'h0);
        decide(4'h1, bmr_pkg::BMR_BOOT);
        // run command arrives while the enable is low: nothing may move
        @(posedge clk);
        ce <= 1'b0;
        run <= 1'b1;
        bank1 <= b1;
        @(posedge clk);
        #1;
        chk("frozen map", {38'h0, bmr_pkg::BMR_BOOT}, {38'h0, map});
        chk("frozen host", 40'h1, {39'h0, hm});
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        #1;
        chk("host map", {38'h0, b1 ? bmr_pkg::BMR_PF1 : bmr_pkg::BMR_PF2}, {38'h0, map});
        chk("host off", 40'h0, {39'h0, hm});
        acc(32'h0000_0000, b1 ? bmr_pkg::TGT_PF1 : bmr_pkg::TGT_PF2, 32'h0);
        // a second run outside host mode is ignored
        @(posedge clk);
        run <= 1'b1;
        bank1 <= ~b1;
        @(posedge clk);
        run <= 1'b0;
        #1;
        chk("run ignored", {38'h0, b1 ? bmr_pkg::BMR_PF1 : bmr_pkg::BMR_PF2}, {38'h0, map});
        $display("test host mode %b done", b1);
    endtask : t_host

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        t_boot_map();
        t_normal(4'b0001, bmr_pkg::BMR_PF1, bmr_pkg::TGT_PF1, bmr_pkg::TGT_PF2);
        t_normal(4'b0010, bmr_pkg::BMR_PF2, bmr_pkg::TGT_PF2, bmr_pkg::TGT_PF1);
        t_normal(4'b1000, bmr_pkg::BMR_PF2, bmr_pkg::TGT_PF2, bmr_pkg::TGT_PF1);
        t_normal(4'b0110, bmr_pkg::BMR_PF2, bmr_pkg::TGT_PF2, bmr_pkg::TGT_PF1);
        t_normal(4'b0100, bmr_pkg::BMR_PF1, bmr_pkg::TGT_PF1, bmr_pkg::TGT_PF2);
        t_host(1'b1);
        t_host(1'b0);
        test_done();
    end
endmodule : boot_memory_map_remap_tb
`default_nettype wire
